// file: hw/sbef_pkg.sv
// shared constants and carrier types for the start-up / brownout / error flag sequencer
package sbef_pkg;
    localparam int unsigned CLK_FREQ_HZ     = 125_000_000;
    localparam int unsigned STARTUP_TIME_NS = 100_000;
    localparam int unsigned BROWNOUT_TIME_NS = 25_000;
    localparam int unsigned OVERRANGE_TIME_NS = 3_000;
    localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_FREQ_HZ;
    // least times, rounded up to whole cycles
    localparam int unsigned STARTUP_CYCLES   =
        (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BROWNOUT_CYCLES  =
        (BROWNOUT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OVERRANGE_CYCLES =
        (OVERRANGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

    typedef enum logic [1:0] {
        SBEF_ST_OFF    = 2'b00,
        SBEF_ST_SETTLE = 2'b01,
        SBEF_ST_RUN    = 2'b11
    } sbef_state_type;

    // supply comparator levels, all asynchronous to clk
    typedef struct packed {
        logic above_por;   // rail above power-on threshold
        logic below_bod;   // rail below brownout level
        logic deep_dip;    // rail at or below deep-dip threshold
    } sbef_supply_type;

    // fault detector levels, all asynchronous to clk
    typedef struct packed {
        logic offset_high; // hall offset beyond limit
        logic hall_open;   // hall terminal disconnected
        logic overload;    // amplifier out of linear range
    } sbef_fault_type;

    // open-drain pin: low only, oe high while pulling down
    typedef struct packed {
        logic o;
        logic oe;
    } sbef_od_type;
endpackage : sbef_pkg

// file: hw/sbef_persist.sv
// persistence filter: output rises once input has stayed high for a set number of cycles
`timescale 1ns/1ps
module sbef_persist #(
    parameter logic [sbef_pkg::CNT_W-1:0] HOLD_CYCLES = 16'h0001
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic level_in,
    output logic      qualified
);
    logic [sbef_pkg::CNT_W-1:0] count_ff;
    logic                       qual_ff;

    always_ff @(posedge clk) begin
        if (rst || !level_in) begin
            count_ff <= sbef_pkg::CNT_ZERO;
        end else if (count_ff != HOLD_CYCLES) begin
            count_ff <= count_ff + sbef_pkg::CNT_ONE;
        end
    end

    // drops at once when input falls; short pulses never reach the count
    always_ff @(posedge clk) begin
        if (rst || !level_in) begin
            qual_ff <= 1'b0;
        end else if (count_ff == HOLD_CYCLES - sbef_pkg::CNT_ONE) begin
            qual_ff <= 1'b1;
        end
    end

    assign qualified = qual_ff;
endmodule : sbef_persist

// file: hw/sbef_sequencer.sv
// power-on / brownout sequencer with error and overrange open-drain flags
//
// How it works
// [RL1] start-up begins when rail passes power-on threshold
// [RL2] wait 100 us settling after power-on
// [RL3] both coil drivers forced low while settling
// [RL4] faults ignored, error flag low while settling
// [RL5] measurement output invalid until settling completes
// [RL6] brownout shorter than 25 us is ignored
// [RL7] brownout longer than 25 us resets device
// [RL8] deep dip resets device regardless of duration
// [RL9] rerun full start-up after any reset
// [RL10] error flag low on excessive hall offset
// [RL11] error flag low on open hall terminal
// [RL12] error flag releases itself once faults clear
// [RL13] flags are open-drain active low, pulled up outside
// [RL14] after brownout, flag held until start-up ends
// [RL15] overrange flag after 3 us overload, releases at end
// [RL16] timers are cycle counters from the clock rate
`timescale 1ns/1ps
module sbef_sequencer (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire sbef_pkg::sbef_supply_type supply,
    input  wire sbef_pkg::sbef_fault_type  fault,
    input  wire logic                     coil_req_pos,
    input  wire logic                     coil_req_neg,
    output logic                          coil_drive_pos,
    output logic                          coil_drive_neg,
    output logic                          measurement_output_valid,
    output sbef_pkg::sbef_od_type          error_n,
    output sbef_pkg::sbef_od_type          overrange_n,
    output logic                          por_pulse
);
    localparam logic [sbef_pkg::CNT_W-1:0] STARTUP_CNT =
        sbef_pkg::CNT_W'(sbef_pkg::STARTUP_CYCLES);
    localparam logic [sbef_pkg::CNT_W-1:0] BROWNOUT_CNT =
        sbef_pkg::CNT_W'(sbef_pkg::BROWNOUT_CYCLES);
    localparam logic [sbef_pkg::CNT_W-1:0] OVERRANGE_CNT =
        sbef_pkg::CNT_W'(sbef_pkg::OVERRANGE_CYCLES);

    // run-state decode shared by drivers, valid and the error flag
    function automatic logic in_run(input sbef_pkg::sbef_state_type st);
        return (st == sbef_pkg::SBEF_ST_RUN);
    endfunction : in_run

    // two-stage synchronisers for all analog comparator levels
    // comparators may chatter near threshold; the persist filters absorb it on below_bod and overload only
    sbef_pkg::sbef_supply_type sup_meta_ff;
    sbef_pkg::sbef_supply_type sup_sync_ff;
    sbef_pkg::sbef_fault_type  flt_meta_ff;
    sbef_pkg::sbef_fault_type  flt_sync_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            sup_meta_ff <= '0;
            sup_sync_ff <= '0;
        end else begin
            sup_meta_ff <= supply;
            sup_sync_ff <= sup_meta_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flt_meta_ff <= '0;
            flt_sync_ff <= '0;
        end else begin
            flt_meta_ff <= fault;
            flt_sync_ff <= flt_meta_ff;
        end
    end

    // brownout qualifier: only dips lasting the full window count
    logic brownout_long;
    sbef_persist #(
        .HOLD_CYCLES(BROWNOUT_CNT)
    ) u_brownout (
        .clk      (clk),
        .rst      (rst),
        .level_in (sup_sync_ff.below_bod),
        .qualified(brownout_long)                            // see [RL6] see [RL7] see [RL16]
    );

    // overload qualifier for the overrange flag
    logic overload_long;
    sbef_persist #(
        .HOLD_CYCLES(OVERRANGE_CNT)
    ) u_overrange (
        .clk      (clk),
        .rst      (rst),
        .level_in (flt_sync_ff.overload),
        .qualified(overload_long)                            // see [RL15] see [RL16]
    );

    // internal power-on reset: long brownout or deep dip
    logic por_event;
    assign por_event = brownout_long || sup_sync_ff.deep_dip; // see [RL7] see [RL8]

    sbef_pkg::sbef_state_type   state_ff;
    sbef_pkg::sbef_state_type   nxt_state;
    logic [sbef_pkg::CNT_W-1:0] settle_cnt_ff;
    logic                       settle_done;

    assign settle_done = (settle_cnt_ff == STARTUP_CNT - sbef_pkg::CNT_ONE); // see [RL2]

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sbef_pkg::SBEF_ST_OFF: begin
                if (!por_event && sup_sync_ff.above_por) begin
                    nxt_state = sbef_pkg::SBEF_ST_SETTLE;          // see [RL1] see [RL9]
                end
            end
            sbef_pkg::SBEF_ST_SETTLE: begin
                if (por_event) begin
                    nxt_state = sbef_pkg::SBEF_ST_OFF;
                end else if (settle_done) begin
                    nxt_state = sbef_pkg::SBEF_ST_RUN;             // see [RL2]
                end
            end
            sbef_pkg::SBEF_ST_RUN: begin
                if (por_event) begin
                    nxt_state = sbef_pkg::SBEF_ST_OFF;             // see [RL7] see [RL8]
                end
            end
            default: begin
                nxt_state = sbef_pkg::SBEF_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= sbef_pkg::SBEF_ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // settling timer runs only in the settle state, so every rerun starts from zero
    always_ff @(posedge clk) begin
        if (rst || state_ff != sbef_pkg::SBEF_ST_SETTLE) begin
            settle_cnt_ff <= sbef_pkg::CNT_ZERO;
        end else begin
            settle_cnt_ff <= settle_cnt_ff + sbef_pkg::CNT_ONE; // see [RL16]
        end
    end

    // one-cycle pulse marking an internal power-on reset taking effect
    logic por_pulse_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            por_pulse_ff <= 1'b0;
        end else begin
            por_pulse_ff <= por_event && (state_ff != sbef_pkg::SBEF_ST_OFF);
        end
    end
    assign por_pulse = por_pulse_ff;

    logic running;
    assign running = in_run(state_ff);

    // drivers and valid registered; drivers off in any non-run state
    logic drive_pos_ff;
    logic drive_neg_ff;
    logic valid_ff;
    always_ff @(posedge clk) begin
        if (rst || !in_run(nxt_state)) begin
            drive_pos_ff <= 1'b0;                               // see [RL3]
            drive_neg_ff <= 1'b0;                               // see [RL3]
        end else begin
            drive_pos_ff <= coil_req_pos;
            drive_neg_ff <= coil_req_neg;
        end
    end

    // keyed to nxt_state so valid drops on the very edge the state leaves run
    always_ff @(posedge clk) begin
        if (rst) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= in_run(nxt_state);                      // see [RL5]
        end
    end

    assign coil_drive_pos           = drive_pos_ff;
    assign coil_drive_neg           = drive_neg_ff;
    assign measurement_output_valid = valid_ff;

    // error flag: held during off/settle, then live fault sources or por_event, no latching
    logic err_ff;
    logic ovr_ff;
    logic fault_live;
    assign fault_live = flt_sync_ff.offset_high       // see [RL10]
                     || flt_sync_ff.hall_open;        // see [RL11]

    always_ff @(posedge clk) begin
        if (rst) begin
            err_ff <= 1'b1;
        end else if (!running) begin
            err_ff <= 1'b1;                           // see [RL4] see [RL14]
        end else begin
            err_ff <= fault_live || por_event;        // see [RL12]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ovr_ff <= 1'b0;
        end else begin
            ovr_ff <= overload_long;                  // see [RL15]
        end
    end

    // pull down only; the high level comes from the external pull-up
    assign error_n.o      = 1'b0;                     // see [RL13]
    assign error_n.oe     = err_ff;                   // see [RL13]
    assign overrange_n.o  = 1'b0;
    assign overrange_n.oe = ovr_ff;                   // see [RL13]
endmodule : sbef_sequencer

// file: bench/sbef_flag_monitor.sv
// system-side model of the wired open-drain flag lines with their pull-ups
`timescale 1ns/1ps
module sbef_flag_monitor (
    input  wire sbef_pkg::sbef_od_type error_n,
    input  wire sbef_pkg::sbef_od_type overrange_n,
    output logic                       error_pin,
    output logic                       overrange_pin,
    output logic                       wired_pin
);
    // pull-up gives the idle high; any enabled driver wins low
    assign error_pin     = error_n.oe ? error_n.o : 1'b1;
    assign overrange_pin = overrange_n.oe ? overrange_n.o : 1'b1;
    assign wired_pin     = error_pin & overrange_pin;
endmodule : sbef_flag_monitor

// file: bench/sbef_checker.sv
// timing checks on the sequencer ports
`timescale 1ns/1ps
module sbef_checker (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire sbef_pkg::sbef_supply_type supply,
    input wire sbef_pkg::sbef_fault_type  fault,
    input wire logic                      coil_req_pos,
    input wire logic                      coil_req_neg,
    input wire logic                      coil_drive_pos,
    input wire logic                      coil_drive_neg,
    input wire logic                      measurement_output_valid,
    input wire sbef_pkg::sbef_od_type     error_n,
    input wire sbef_pkg::sbef_od_type     overrange_n,
    input wire logic                      por_pulse
);
    logic [15:0] bod_ff, last_ff, ovl_ff, set_ff;
    logic [7:0]  dd_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // last_ff keeps the length of the latest low-supply run after it ends
    always_ff @(posedge clk) bod_ff <= (rst || !supply.below_bod) ? 16'h0000 : bod_ff + 16'h0001;
    always_ff @(posedge clk) last_ff <= rst ? 16'h0000
                                        : (supply.below_bod ? bod_ff + 16'h0001 : last_ff);
    always_ff @(posedge clk) ovl_ff <= (rst || !fault.overload) ? 16'h0000 : ovl_ff + 16'h0001;
    always_ff @(posedge clk) set_ff <= (rst || por_pulse || !supply.above_por) ? 16'h0000
                                       : set_ff + {15'h0000, ~&set_ff};
    always_ff @(posedge clk) dd_ff <= rst ? 8'h00 : {dd_ff[6:0], supply.deep_dip};
    sequence reset_seen;
        ##[1:5] por_pulse;
    endsequence
    drv_idle_a: assert property (!measurement_output_valid
        |-> !coil_drive_pos && !coil_drive_neg)
        else $error("coil drive active before start-up ended");
    drv_follow_a: assert property (measurement_output_valid
        |-> coil_drive_pos == $past(coil_req_pos) && coil_drive_neg == $past(coil_req_neg))
        else $error("coil drive not following request");
    err_settle_a: assert property (!measurement_output_valid |-> error_n.oe)
        else $error("error flag released while not running");
    err_run_a: assert property (measurement_output_valid
        && $past(measurement_output_valid, 3)
        |-> error_n.oe == ($past(fault.offset_high, 3) || $past(fault.hall_open, 3)))
        else $error("error flag does not match fault inputs");
    settle_len_a: assert property ($rose(measurement_output_valid)
        |-> set_ff >= sbef_pkg::STARTUP_CYCLES)
        else $error("start-up wait too short");
    bod_len_a: assert property (por_pulse && dd_ff == 8'h00
        |-> last_ff >= sbef_pkg::BROWNOUT_CYCLES)
        else $error("reset from a short supply dip");
    dip_reset_a: assert property (supply.deep_dip && measurement_output_valid
        |-> reset_seen)
        else $error("deep dip gave no reset");
    ovr_len_a: assert property ($rose(overrange_n.oe)
        |-> $past(ovl_ff, 3) >= sbef_pkg::OVERRANGE_CYCLES)
        else $error("overrange flag raised too early");
    od_low_a: assert property (error_n.o == 1'b0 && overrange_n.o == 1'b0)
        else $error("flag output drives high");
endmodule : sbef_checker

bind sbef_sequencer sbef_checker i_chk (.clk, .rst, .supply, .fault, .coil_req_pos, .coil_req_neg,
    .coil_drive_pos, .coil_drive_neg, .measurement_output_valid, .error_n, .overrange_n, .por_pulse);

// file: bench/sbef_sequencer_test.sv
// self-checking bench for the start-up / brownout sequencer
`timescale 1ns/1ps
module sbef_sequencer_test;
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    sbef_pkg::sbef_supply_type supply = 3'h0;
    sbef_pkg::sbef_fault_type  fault = 3'h0;
    logic                      req_p = 1'b0;
    logic                      req_n = 1'b0;
    logic                      drv_p, drv_n, valid, por_pulse, err_pin, ovr_pin, wired;
    sbef_pkg::sbef_od_type     error_n, overrange_n;
    int                        miscompares = 0;
    int                        n_tests = 0;
    int                        pulses = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (por_pulse === 1'b1) pulses <= pulses + 1;
    sbef_sequencer i_dut (.clk, .rst, .supply, .fault, .coil_req_pos(req_p), .coil_req_neg(req_n),
        .coil_drive_pos(drv_p), .coil_drive_neg(drv_n), .measurement_output_valid(valid),
        .error_n, .overrange_n, .por_pulse);
    sbef_flag_monitor i_mon (.error_n, .overrange_n, .error_pin(err_pin), .overrange_pin(ovr_pin),
        .wired_pin(wired));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // settle with a fault present: it must be masked until running
    task automatic power_up;
        cyc(1);
        rst <= 1'b0;
        supply.above_por <= 1'b1;
        req_p <= 1'b1;
        fault.offset_high <= 1'b1;
        cyc(100);
        #2;
        chk("drive", {14'h0, drv_p, drv_n}, 16'h0000);
        chk("err", {15'h0, err_pin}, 16'h0000);
        cyc(12300);
        fault <= 3'h0;
        #2;
        chk("valid", {15'h0, valid}, 16'h0000);
        cyc(300);
        #2;
        chk("valid", {15'h0, valid}, 16'h0001);
        chk("drive", {14'h0, drv_p, drv_n}, 16'h0002);
        chk("err", {15'h0, err_pin}, 16'h0001);
    endtask : power_up
    // once running, both drivers follow their requests a cycle later
    task automatic coil_follow;
        cyc(1);
        req_p <= 1'b0;
        req_n <= 1'b1;
        cyc(2);
        #2;
        chk("drive", {14'h0, drv_p, drv_n}, 16'h0001);
        cyc(1);
        req_p <= 1'b1;
        req_n <= 1'b0;
        cyc(2);
        #2;
        chk("drive", {14'h0, drv_p, drv_n}, 16'h0002);
    endtask : coil_follow
    task automatic hall_faults;
        for (int i = 0; i < 2; i++) begin
            cyc(1);
            fault <= (i == 0) ? 3'h4 : 3'h2;
            cyc(5);
            #2;
            chk("err", {15'h0, err_pin}, 16'h0000);
            cyc(1);
            fault <= 3'h0;
            cyc(5);
            #2;
            chk("err", {15'h0, err_pin}, 16'h0001);
        end
    endtask : hall_faults
    task automatic overload;
        cyc(1);
        fault.overload <= 1'b1;
        cyc(360);
        #2;
        chk("ovr", {15'h0, ovr_pin}, 16'h0001);
        cyc(30);
        fault.overload <= 1'b0;
        #2;
        chk("ovr", {15'h0, ovr_pin}, 16'h0000);
        chk("wired", {15'h0, wired}, 16'h0000);
        cyc(5);
        #2;
        chk("ovr", {15'h0, ovr_pin}, 16'h0001);
        chk("wired", {15'h0, wired}, 16'h0001);
    endtask : overload
    task automatic brownout;
        cyc(1);
        supply.below_bod <= 1'b1;
        cyc(3000);
        supply.below_bod <= 1'b0;
        cyc(10);
        #2;
        chk("pulses", 16'(pulses), 16'h0000);
        chk("valid", {15'h0, valid}, 16'h0001);
        cyc(1);
        supply.below_bod <= 1'b1;
        cyc(3200);
        #2;
        chk("pulses", 16'(pulses), 16'h0001);
        chk("flags", {13'h0, valid, err_pin, drv_p}, 16'h0000);
        cyc(1);
        supply.below_bod <= 1'b0;
        cyc(12400);
        #2;
        chk("valid", {15'h0, valid}, 16'h0000);
        cyc(200);
        #2;
        chk("flags", {14'h0, valid, err_pin}, 16'h0003);
    endtask : brownout
    task automatic deep_dip;
        cyc(1);
        supply.deep_dip <= 1'b1;
        cyc(1);
        supply.deep_dip <= 1'b0;
        cyc(6);
        #2;
        chk("pulses", 16'(pulses), 16'h0002);
        chk("valid", {15'h0, valid}, 16'h0000);
        chk("err", {15'h0, err_pin}, 16'h0000);
        cyc(12600);
        #2;
        chk("valid", {15'h0, valid}, 16'h0001);
    endtask : deep_dip
    initial begin
        cyc(5);
        power_up();
        coil_follow();
        hall_faults();
        overload();
        brownout();
        deep_dip();
        report_and_stop();
    end
    // about 45k cycles expected; the limit at 75k cycles leaves a margin
    initial begin
        #600_000;
        miscompares++;
        report_and_stop();
    end
endmodule : sbef_sequencer_test
